/* File: dcm_consts.svh */
// constants for the dual core message interface
`ifndef DCM_CONSTS_SVH
`define DCM_CONSTS_SVH
`define DCM_DATA_W 16
`define DCM_VEC_W 8
`define DCM_FLAG_W 3
// controller control word enable positions
`define DCM_EN_RX0 15
`define DCM_EN_RX1 14
`define DCM_EN_TX0 13
`define DCM_EN_TX1 12
`define DCM_EN_GEN0 11
`define DCM_EN_GEN1 10
// controller status word positions
`define DCM_ST_RXF0 15
`define DCM_ST_RXF1 14
`define DCM_ST_TXE0 13
`define DCM_ST_TXE1 12
`define DCM_ST_GEN_HI 11
`define DCM_ST_GEN_LO 10
`define DCM_ST_CMD_BUSY 9
`define DCM_ST_WAKE_BUSY 8
`define DCM_ST_PEER_RST 7
`define DCM_ST_FLAG_HI 6
`define DCM_ST_FLAG_LO 4
`define DCM_ST_MODE_HI 3
`define DCM_ST_MODE_LO 2
`define DCM_ST_PEER_STOP 1
`define DCM_ST_EVT_BUSY 0
// event channel indices, controller to signal processor then back
`define DCM_EV_C_TX0 0
`define DCM_EV_C_TX1 1
`define DCM_EV_C_RX0 2
`define DCM_EV_C_RX1 3
`define DCM_EV_CMD 4
`define DCM_EV_WAKE 5
`define DCM_EV_S_TX0 6
`define DCM_EV_S_TX1 7
`define DCM_EV_S_RX0 8
`define DCM_EV_S_RX1 9
`define DCM_EV_GEN0 10
`define DCM_EV_GEN1 11
`define DCM_NEV 12
// reset values
`define DCM_TXE_RST 2'h3
`define DCM_RXF_RST 2'h0
`endif

/* File: dcm_evt_sync.sv */
// event crossing with toggle request and acknowledge handshake
`timescale 1ns/100ps
module dcm_evt_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sending side
  input wire logic evt,
  output logic busy,
  // receiving side
  output logic evtOut
);
  logic reqQ, reqD, pendQ, pendD;
  logic s1Q, s2Q, s3Q;
  logic a1Q, a2Q;
  logic launch;

  // one event may wait behind one in flight; a third merges with it
  always_comb
  begin
    launch = (evt | pendQ) & ~(reqQ ^ a2Q);
    reqD = reqQ ^ launch;
    pendD = (pendQ | evt) & ~launch;
    busy = (reqQ ^ a2Q) | pendQ;
    evtOut = s2Q ^ s3Q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reqQ <= 1'b0;
      pendQ <= 1'b0;
      s1Q <= 1'b0;
      s2Q <= 1'b0;
      s3Q <= 1'b0;
      a1Q <= 1'b0;
      a2Q <= 1'b0;
    end
    else
    begin
      reqQ <= reqD;
      pendQ <= pendD;
      s1Q <= reqQ;
      s2Q <= s1Q;
      s3Q <= s2Q;
      a1Q <= s2Q;
      a2Q <= a1Q;
    end
  end
endmodule : dcm_evt_sync

/* File: dcm_message_if.sv */
// controller to signal processor message and interrupt block
`timescale 1ns/100ps
`include "dcm_consts.svh"
module dcm_message_if (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller message port
  input wire logic [1:0] ctlTxWr,
  input wire logic [15:0] ctlTxData,
  input wire logic [1:0] ctlRxRd,
  output logic [1:0][15:0] ctlRxData,
  // controller control bits
  input wire logic [15:0] ctlControl,
  input wire logic [2:0] ctlFlags,
  input wire dcm_pkg::dcm_pmode_t ctlMode,
  input wire logic [1:0] ctlGenClear,
  input wire logic ctlCmdTrigger,
  input wire dcm_pkg::dcm_cmd_t ctlCmd,
  input wire logic ctlWakeFromStop,
  input wire logic ctlPeerReset,
  input wire logic ctlBlockReset,
  // controller status and request
  output logic [15:0] ctlStatus,
  output logic ctlIrq,
  // signal processor message port
  input wire logic [1:0] spTxWr,
  input wire logic [15:0] spTxData,
  input wire logic [1:0] spRxRd,
  output logic [1:0][15:0] spRxData,
  // signal processor control bits
  input wire logic [2:0] spFlags,
  input wire dcm_pkg::dcm_pmode_t spMode,
  input wire logic [3:0] spRxTxIrqEnable,
  input wire logic spCmdIrqEnable,
  input wire logic spCmdAck,
  input wire logic spWakeClear,
  input wire logic [1:0] spGenReq,
  // signal processor status and interrupts
  output dcm_pkg::dcm_sp_stat_t spStatus,
  output logic spCmdIrq,
  output logic spCmdIsNmi,
  output logic [7:0] spCmdVector,
  output logic spRxTxIrq,
  output logic [1:0] spRxTxSrc,
  output logic spWakeIrq,
  output logic spResetOut
);
  logic srst;
  logic [`DCM_NEV-1:0] evIn, evOut, evBusy;
  logic [4:0] c2sS1Q, c2sS2Q, s2cS1Q, s2cS2Q;
  logic peerStop;

  // controller side state
  logic [1:0][15:0] cTxQ, cTxD, cRxQ, cRxD;
  logic [1:0] cTxeQ, cTxeD, cRxfQ, cRxfD, cGenQ, cGenD;
  dcm_pkg::dcm_cmd_t cCmdQ, cCmdD;
  logic cPeerRstQ;

  // signal processor side state
  logic [1:0][15:0] sTxQ, sTxD, sRxQ, sRxD;
  logic [1:0] sTxeQ, sTxeD, sRxfQ, sRxfD, sGenQ, sGenD;
  logic sCmdPendQ, sCmdPendD, sWakeQ, sWakeD;
  dcm_pkg::dcm_cmd_t sCmdQ, sCmdD;
  logic [3:0] sRtAct;

  // peer stop taken from the mirrored mode so both sides agree on it
  assign peerStop = (s2cS2Q[1:0] == dcm_pkg::DCM_STOP);
  // block reset held off while the processor is stopped
  assign srst = rst | (ctlBlockReset & ~peerStop);

  // event sources, one per channel
  always_comb
  begin
    evIn = '0;
    evIn[`DCM_EV_C_TX0] = ctlTxWr[0];
    evIn[`DCM_EV_C_TX1] = ctlTxWr[1];
    evIn[`DCM_EV_C_RX0] = ctlRxRd[0];
    evIn[`DCM_EV_C_RX1] = ctlRxRd[1];
    evIn[`DCM_EV_CMD] = ctlCmdTrigger;
    evIn[`DCM_EV_WAKE] = ctlWakeFromStop;
    evIn[`DCM_EV_S_TX0] = spTxWr[0];
    evIn[`DCM_EV_S_TX1] = spTxWr[1];
    evIn[`DCM_EV_S_RX0] = spRxRd[0];
    evIn[`DCM_EV_S_RX1] = spRxRd[1];
    evIn[`DCM_EV_GEN0] = spGenReq[0] & ~sGenQ[0];
    evIn[`DCM_EV_GEN1] = spGenReq[1] & ~sGenQ[1];
  end

  // every event crosses by handshake; a queued second one bounds latency
  generate
    for (genvar i = 0; i < `DCM_NEV; i++)
    begin : gEvt
      dcm_evt_sync uSync (
        .clk(clk),
        .rst(srst),
        .evt(evIn[i]),
        .busy(evBusy[i]),
        .evtOut(evOut[i])
      );
    end
  endgenerate

  // level mirrors: flags and power modes, two stages each way
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      c2sS1Q <= '0;
      c2sS2Q <= '0;
      s2cS1Q <= '0;
      s2cS2Q <= '0;
    end
    else
    begin
      c2sS1Q <= {ctlFlags, ctlMode};
      c2sS2Q <= c2sS1Q;
      s2cS1Q <= {spFlags, spMode};
      s2cS2Q <= s2cS1Q;
    end
  end

  // controller side next values; arriving sets win over local clears
  always_comb
  begin
    cTxD = cTxQ;
    cRxD = cRxQ;
    for (int k = 0; k < 2; k++)
    begin
      if (ctlTxWr[k])
      begin
        cTxD[k] = ctlTxData;
      end
      if (evOut[`DCM_EV_S_TX0 + k])
      begin
        cRxD[k] = sTxQ[k];
      end
    end
    cTxeD = (cTxeQ & ~ctlTxWr) | evOut[`DCM_EV_S_RX1:`DCM_EV_S_RX0];
    cRxfD = (cRxfQ & ~ctlRxRd) | evOut[`DCM_EV_S_TX1:`DCM_EV_S_TX0];
    cGenD = (cGenQ & ~ctlGenClear) | evOut[`DCM_EV_GEN1:`DCM_EV_GEN0];
    cCmdD = ctlCmdTrigger ? ctlCmd : cCmdQ;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cTxQ <= '0;
      cRxQ <= '0;
      cTxeQ <= `DCM_TXE_RST;
      cRxfQ <= `DCM_RXF_RST;
      cGenQ <= '0;
      cCmdQ <= '0;
    end
    else
    begin
      cTxQ <= cTxD;
      cRxQ <= cRxD;
      cTxeQ <= cTxeD;
      cRxfQ <= cRxfD;
      cGenQ <= cGenD;
      cCmdQ <= cCmdD;
    end
  end

  // peer reset follows the plain system reset only, not the block reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cPeerRstQ <= 1'b0;
    end
    else
    begin
      cPeerRstQ <= ctlPeerReset;
    end
  end

  // controller status word and its single request line
  always_comb
  begin
    ctlStatus = '0;
    ctlStatus[`DCM_ST_RXF0] = cRxfQ[0];
    ctlStatus[`DCM_ST_RXF1] = cRxfQ[1];
    ctlStatus[`DCM_ST_TXE0] = cTxeQ[0];
    ctlStatus[`DCM_ST_TXE1] = cTxeQ[1];
    ctlStatus[`DCM_ST_GEN_HI:`DCM_ST_GEN_LO] = {cGenQ[1], cGenQ[0]};
    ctlStatus[`DCM_ST_CMD_BUSY] = evBusy[`DCM_EV_CMD] | sCmdPendQ;
    ctlStatus[`DCM_ST_WAKE_BUSY] = evBusy[`DCM_EV_WAKE] | sWakeQ;
    ctlStatus[`DCM_ST_PEER_RST] = cPeerRstQ;
    ctlStatus[`DCM_ST_FLAG_HI:`DCM_ST_FLAG_LO] = s2cS2Q[4:2];
    ctlStatus[`DCM_ST_MODE_HI:`DCM_ST_MODE_LO] = s2cS2Q[1:0];
    ctlStatus[`DCM_ST_PEER_STOP] = peerStop;
    ctlStatus[`DCM_ST_EVT_BUSY] = |evBusy[`DCM_EV_WAKE:`DCM_EV_C_TX0];
  end

  // each source gated by its enable; the status word names the source
  assign ctlIrq = (cRxfQ[0] & ctlControl[`DCM_EN_RX0])
                | (cRxfQ[1] & ctlControl[`DCM_EN_RX1])
                | (cTxeQ[0] & ctlControl[`DCM_EN_TX0])
                | (cTxeQ[1] & ctlControl[`DCM_EN_TX1])
                | (cGenQ[0] & ctlControl[`DCM_EN_GEN0])
                | (cGenQ[1] & ctlControl[`DCM_EN_GEN1]);

  assign ctlRxData = cRxQ;

  // signal processor side next values
  always_comb
  begin
    sTxD = sTxQ;
    sRxD = sRxQ;
    for (int k = 0; k < 2; k++)
    begin
      if (spTxWr[k])
      begin
        sTxD[k] = spTxData;
      end
      if (evOut[`DCM_EV_C_TX0 + k])
      begin
        sRxD[k] = cTxQ[k];
      end
    end
    sTxeD = (sTxeQ & ~spTxWr) | evOut[`DCM_EV_C_RX1:`DCM_EV_C_RX0];
    sRxfD = (sRxfQ & ~spRxRd) | evOut[`DCM_EV_C_TX1:`DCM_EV_C_TX0];
    // a general request bit stays up until its event has been taken
    sGenD = (sGenQ & evBusy[`DCM_EV_GEN1:`DCM_EV_GEN0]) | spGenReq;
    sCmdPendD = (sCmdPendQ & ~spCmdAck) | evOut[`DCM_EV_CMD];
    sCmdD = evOut[`DCM_EV_CMD] ? cCmdQ : sCmdQ;
    sWakeD = (sWakeQ & ~spWakeClear) | evOut[`DCM_EV_WAKE];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sTxQ <= '0;
      sRxQ <= '0;
      sTxeQ <= `DCM_TXE_RST;
      sRxfQ <= `DCM_RXF_RST;
      sGenQ <= '0;
      sCmdPendQ <= 1'b0;
      sCmdQ <= '0;
      sWakeQ <= 1'b0;
    end
    else
    begin
      sTxQ <= sTxD;
      sRxQ <= sRxD;
      sTxeQ <= sTxeD;
      sRxfQ <= sRxfD;
      sGenQ <= sGenD;
      sCmdPendQ <= sCmdPendD;
      sCmdQ <= sCmdD;
      sWakeQ <= sWakeD;
    end
  end

  // processor status record
  always_comb
  begin
    spStatus.rxFull = sRxfQ;
    spStatus.txEmpty = sTxeQ;
    spStatus.cmdPending = sCmdPendQ;
    spStatus.genReq = sGenQ;
    spStatus.peerFlags = c2sS2Q[4:2];
    spStatus.peerMode = dcm_pkg::dcm_pmode_t'(c2sS2Q[1:0]);
    spStatus.evtBusy = |evBusy[`DCM_EV_GEN1:`DCM_EV_S_TX0];
  end

  // command interrupt: nonmaskable bypasses the processor enable,
  // but only when the controller armed nonmaskable delivery; an unarmed one is never raised
  always_comb
  begin
    if (sCmdQ.nmi)
    begin
      spCmdIrq = sCmdPendQ & sCmdQ.nmiEnable;
    end
    else
    begin
      spCmdIrq = sCmdPendQ & spCmdIrqEnable;
    end
  end

  assign spCmdIsNmi = sCmdQ.nmi & sCmdQ.nmiEnable;
  assign spCmdVector = sCmdQ.vector;

  // receive and transmit sources in fixed order, lowest index first
  assign sRtAct = {sTxeQ[1], sTxeQ[0], sRxfQ[1], sRxfQ[0]} & spRxTxIrqEnable;
  always_comb
  begin
    spRxTxSrc = 2'h0;
    if (sRtAct[0])
    begin
      spRxTxSrc = 2'h0;
    end
    else if (sRtAct[1])
    begin
      spRxTxSrc = 2'h1;
    end
    else if (sRtAct[2])
    begin
      spRxTxSrc = 2'h2;
    end
    else if (sRtAct[3])
    begin
      spRxTxSrc = 2'h3;
    end
    else
    begin
      spRxTxSrc = 2'h0;
    end
  end

  assign spRxTxIrq = |sRtAct;
  assign spWakeIrq = sWakeQ;
  assign spResetOut = cPeerRstQ;
  assign spRxData = sRxQ;
endmodule : dcm_message_if

/* File: dcm_message_if_properties.sv */
// property checker for the message block
`timescale 1ns/100ps
module dcm_message_if_properties (
  // watched top-level ports
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] ctlTxWr,
  input wire logic [15:0] ctlTxData,
  input wire logic [15:0] ctlControl,
  input wire dcm_pkg::dcm_pmode_t ctlMode,
  input wire logic ctlPeerReset,
  input wire logic ctlBlockReset,
  input wire logic [15:0] ctlStatus,
  input wire logic ctlIrq,
  input wire logic [1:0] spRxRd,
  input wire logic [1:0][15:0] spRxData,
  input wire logic [3:0] spRxTxIrqEnable,
  input wire logic spCmdIrqEnable,
  input wire logic spCmdAck,
  input wire dcm_pkg::dcm_sp_stat_t spStatus,
  input wire logic spCmdIrq,
  input wire logic spCmdIsNmi,
  input wire logic spRxTxIrq,
  input wire logic [1:0] spRxTxSrc,
  input wire logic spResetOut
);
  logic [3:0] pend;
  logic [1:0] pSrc;
  always_comb
  begin
    pend = {spStatus.txEmpty, spStatus.rxFull} & spRxTxIrqEnable;
    pSrc = pend[0] ? 2'h0 : pend[1] ? 2'h1 : pend[2] ? 2'h2 : 2'h3;
  end
  default clocking @(posedge clk); endclocking
  // block reset silences every check, even in stop where the block holds it off
  default disable iff (rst || ctlBlockReset);
  AST_TXE_CLR:
    assert property (ctlTxWr[0] |=> !ctlStatus[13]) else $error("tx0 empty kept");
  AST_RXF_SET:
    assert property (ctlTxWr[0] && !ctlStatus[0] |-> ##4 spStatus.rxFull[0])
      else $error("rx0 full late");
  AST_DATA:
    assert property (ctlTxWr[0] && !ctlStatus[0] |-> ##4 spRxData[0] == $past(ctlTxData, 4))
      else $error("rx0 data wrong");
  AST_RXF_CLR:
    assert property (spRxRd[0] && !ctlStatus[0] |=> !spStatus.rxFull[0])
      else $error("rx0 full kept");
  AST_CTL_IRQ:
    assert property (ctlIrq == (|(ctlStatus[15:12] & ctlControl[15:12])
      || ctlStatus[10] && ctlControl[11] || ctlStatus[11] && ctlControl[10]))
      else $error("controller request wrong");
  AST_PRIO:
    assert property (spRxTxIrq == |pend && (pend == 4'h0 || spRxTxSrc == pSrc))
      else $error("rx tx priority wrong");
  AST_CMD_MASK:
    assert property (spStatus.cmdPending && !spCmdIsNmi |-> spCmdIrq == spCmdIrqEnable)
      else $error("command mask wrong");
  AST_CMD_ACK:
    assert property (spCmdAck |=> !spStatus.cmdPending) else $error("command pending kept");
  AST_PEER_RST:
    assert property (ctlPeerReset |=> spResetOut) else $error("peer reset missing");
  AST_MODE:
    assert property ($stable(ctlMode) && ctlMode == $past(ctlMode, 2)
      |-> spStatus.peerMode == ctlMode)
      else $error("mode mirror wrong");
  AST_STOP:
    assert property (ctlStatus[1] == (ctlStatus[3:2] == 2'h3)) else $error("stop flag wrong");
  cover property (spCmdIrq && spCmdIsNmi);
  cover property (spRxTxIrq && spRxTxSrc == 2'h1);
  cover property (ctlIrq && ctlStatus[10]);
endmodule : dcm_message_if_properties
bind dcm_message_if dcm_message_if_properties u_dcm_message_if_properties (.clk, .rst,
  .ctlTxWr, .ctlTxData, .ctlControl, .ctlMode, .ctlPeerReset, .ctlBlockReset, .ctlStatus,
  .ctlIrq, .spRxRd, .spRxData, .spRxTxIrqEnable, .spCmdIrqEnable, .spCmdAck, .spStatus,
  .spCmdIrq, .spCmdIsNmi, .spRxTxIrq, .spRxTxSrc, .spResetOut);

/* File: dcm_pkg.sv */
// types for the dual core message interface
package dcm_pkg;
  typedef enum logic [1:0] {DCM_RUN, DCM_WAIT, DCM_DOZE, DCM_STOP} dcm_pmode_t;
  typedef struct packed {
    logic [1:0] rxFull;
    logic [1:0] txEmpty;
    logic cmdPending;
    logic [1:0] genReq;
    logic [2:0] peerFlags;
    dcm_pmode_t peerMode;
    logic evtBusy;
  } dcm_sp_stat_t;
  typedef struct packed {
    logic nmi;
    logic nmiEnable;
    logic [7:0] vector;
  } dcm_cmd_t;
endpackage : dcm_pkg

/* File: dcm_sp_model.sv */
// signal processor stand-in: acknowledges command and clears wake
`timescale 1ns/100ps
module dcm_sp_model (
  // clock, speed choice, interrupt lines
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic cmdIrq,
  input wire logic wakeIrq,
  output logic cmdAck,
  output logic wakeClear
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  always_comb
  begin
    cnt_d = (rst || !cmdIrq || cmdAck) ? 3'h0 : cnt_q + 3'h1;
  end
  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_d;
  end
  // slow mode stretches the service delay like a busy core would
  assign cmdAck = cmdIrq && cnt_q == (slow ? 3'h5 : 3'h1);
  assign wakeClear = wakeIrq;
endmodule : dcm_sp_model

/* File: testbench.sv */
// self-checking bench for the message block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0, rst = 1'h1, slow = 1'h0, ctlCmdTrigger = 1'h0, ctlWakeFromStop = 1'h0;
  logic ctlPeerReset = 1'h0, ctlBlockReset = 1'h0, spCmdIrqEnable = 1'h0;
  logic [1:0] ctlTxWr = 2'h0, ctlRxRd = 2'h0, ctlGenClear = 2'h0, spTxWr = 2'h0;
  logic [1:0] spRxRd = 2'h0, spGenReq = 2'h0, spRxTxSrc;
  logic [15:0] ctlTxData = 16'h0, ctlControl = 16'hFC00, spTxData = 16'h0, ctlStatus;
  logic [2:0] ctlFlags = 3'h0, spFlags = 3'h0;
  logic [3:0] spRxTxIrqEnable = 4'hF;
  logic [7:0] spCmdVector;
  logic [1:0][15:0] ctlRxData, spRxData;
  logic ctlIrq, spCmdIrq, spCmdIsNmi, spRxTxIrq, spWakeIrq, spResetOut, spCmdAck, spWakeClear;
  dcm_pkg::dcm_pmode_t ctlMode = dcm_pkg::DCM_RUN, spMode = dcm_pkg::DCM_RUN;
  dcm_pkg::dcm_cmd_t ctlCmd = 10'h0;
  dcm_pkg::dcm_sp_stat_t spStatus;
  int mismatches = 0, compares = 0;
  dcm_message_if u_dcm_message_if (.*);
  dcm_sp_model u_dcm_sp_model (.clk, .rst, .slow, .cmdIrq(spCmdIrq), .wakeIrq(spWakeIrq),
    .cmdAck(spCmdAck), .wakeClear(spWakeClear));
  always #50 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic ctlWr(input int k, input logic [15:0] d);
    ctlTxData = d;
    ctlTxWr[k] = 1'h1;
    tick(1);
    ctlTxWr = 2'h0;
  endtask : ctlWr
  task automatic spRd(input int k);
    spRxRd[k] = 1'h1;
    tick(1);
    spRxRd = 2'h0;
  endtask : spRd
  task automatic spWr(input int k, input logic [15:0] d);
    spTxData = d;
    spTxWr[k] = 1'h1;
    tick(1);
    spTxWr = 2'h0;
  endtask : spWr
  task automatic ctlRd(input int k);
    ctlRxRd[k] = 1'h1;
    tick(1);
    ctlRxRd = 2'h0;
  endtask : ctlRd
  task automatic cmd(input logic [9:0] c);
    ctlCmd = c;
    ctlCmdTrigger = 1'h1;
    tick(1);
    ctlCmdTrigger = 1'h0;
    tick(4);
  endtask : cmd
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial
  begin
    tick(12);
    rst = 1'h0;
    ctlWr(0, 16'hA5C3);
    tick(1);
    chk(ctlStatus[13], 1'h0);
    tick(3);
    chk(spRxData[0], 16'hA5C3);
    chk({spRxTxIrq, spRxTxSrc}, 3'h4);
    ctlWr(1, 16'h5A3C);
    tick(4);
    chk({spRxData[1], 2'h0, spStatus.rxFull}, 20'h5A3C3);
    spRd(0);
    tick(1);
    chk({spRxTxIrq, spRxTxSrc}, 3'h5);
    spRd(1);
    tick(1);
    chk({spRxTxIrq, spRxTxSrc}, 3'h6);
    tick(3);
    chk({ctlIrq, ctlStatus[15:12]}, 5'h13);
    ctlControl = 16'h0C00;
    tick(1);
    chk(ctlIrq, 1'h0);
    spGenReq = 2'h1;
    tick(1);
    spGenReq = 2'h0;
    tick(4);
    chk({ctlIrq, ctlStatus[11:10]}, 3'h5);
    ctlGenClear = 2'h1;
    tick(1);
    ctlGenClear = 2'h0;
    tick(1);
    chk(ctlIrq, 1'h0);
    cmd(10'h03C);
    chk({spCmdVector, spStatus.cmdPending, spCmdIrq}, 10'h0F2);
    spCmdIrqEnable = 1'h1;
    tick(4);
    chk(spStatus.cmdPending, 1'h0);
    spCmdIrqEnable = 1'h0;
    slow = 1'h1;
    cmd(10'h3C3);
    chk({spStatus.cmdPending, spCmdIrq, spCmdIsNmi}, 3'h7);
    tick(8);
    chk(spStatus.cmdPending, 1'h0);
    cmd(10'h211);
    chk(spCmdIrq, 1'h0);
    ctlWakeFromStop = 1'h1;
    tick(1);
    ctlWakeFromStop = 1'h0;
    // the stand-in clears wake one edge after it rises, so look right away
    tick(3);
    chk(spWakeIrq, 1'h1);
    tick(2);
    chk(spWakeIrq, 1'h0);
    ctlFlags = 3'h5;
    ctlMode = dcm_pkg::DCM_STOP;
    spMode = dcm_pkg::DCM_STOP;
    tick(3);
    chk({spStatus.peerFlags, spStatus.peerMode, ctlStatus[3:1]}, 8'hBF);
    ctlBlockReset = 1'h1;
    tick(1);
    ctlBlockReset = 1'h0;
    tick(1);
    chk(spStatus.cmdPending, 1'h1);
    ctlFlags = 3'h0;
    ctlMode = dcm_pkg::DCM_RUN;
    spMode = dcm_pkg::DCM_RUN;
    tick(3);
    ctlBlockReset = 1'h1;
    tick(1);
    ctlBlockReset = 1'h0;
    tick(1);
    chk({ctlStatus, 3'h0, spStatus.cmdPending}, 20'h30000);
    ctlPeerReset = 1'h1;
    tick(1);
    chk(spResetOut, 1'h1);
    ctlPeerReset = 1'h0;
    tick(2);
    spFlags = 3'h6;
    spWr(0, 16'hC35A);
    tick(3);
    chk({ctlRxData[0], ctlStatus[15], ctlStatus[6:4], spStatus.txEmpty}, 22'h30D6BA);
    ctlRd(0);
    tick(3);
    chk({spStatus.txEmpty, ctlStatus[15]}, 3'h6);
    // two writes on one channel back to back: the second is queued
    ctlTxData = 16'h1111;
    ctlTxWr[1] = 1'h1;
    tick(1);
    ctlTxData = 16'h2222;
    tick(1);
    ctlTxWr = 2'h0;
    tick(3);
    spRd(1);
    tick(6);
    chk({spStatus.rxFull[1], spRxData[1], ctlStatus[12], ctlStatus[0]}, 19'h4888A);
    conclude();
  end
  // tests need about 100 cycles; the guard allows thirty times that
  initial
  begin
    #300000;
    mismatches++;
    conclude();
  end
endmodule : testbench
